/* verilog/mcrb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mcrb_defs.svh"
module mcrb_top
    import mcrb_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RST_N_IN,
    // apb slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic             PREADY_OUT,
    output logic [31:0]      PRDATA_OUT,
    output logic             PSLVERR_OUT,
    // core side
    input  wire mcrb_core_cmd_t CORE_CMD_IN,
    input  wire logic        ACC_WR_IN,
    input  wire logic [7:0]  ACC_DATA_IN,
    output logic [7:0]       ACC_OUT,
    // interrupt sources
    input  wire logic [7:0]  IRQ_FLAGS1_IN,
    input  wire logic [7:0]  IRQ_FLAGS2_IN,
    output logic             IRQ_REQ_OUT,
    output logic             EXT_IRQ_EDGE_OUT,
    // counter and watchdog
    input  wire logic        INSTR_CYCLE_TICK_IN,
    input  wire logic        COUNTER_PIN_IN,
    output logic             COUNTER_INC_OUT,
    input  wire logic        WDT_CLK_TICK_IN,
    output logic             WDT_TICK_OUT,
    output logic             WDT_ENABLE_OUT,
    // port six bit zero pin read path
    input  wire logic        PORT6_BIT0_PIN_IN,
    output logic             PORT6_BIT0_READ_OUT,
    // pad controls
    output logic [7:0]       PORT5_DIR_OUT,
    output logic [7:0]       PORT6_DIR_OUT,
    output logic [7:0]       PORT7_DIR_OUT,
    output logic [7:0]       PORT8_DIR_OUT,
    output logic [7:0]       PULL_DOWN2_N_OUT,
    output logic [7:0]       OPEN_DRAIN_OUT,
    output logic [7:0]       PULL_HIGH2_N_OUT
);

    localparam int NREG = `MCRB_NUM_REGS;

    function automatic logic [7:0] impl_mask(input int idx);
        case (idx)
            0:       impl_mask = `MCRB_IMPL_COUNTER_AND_INT_CONTROL;
            1:       impl_mask = `MCRB_IMPL_DIR5;
            2:       impl_mask = `MCRB_IMPL_DIR6;
            3:       impl_mask = `MCRB_IMPL_DIR7;
            4:       impl_mask = `MCRB_IMPL_DIR8;
            5:       impl_mask = `MCRB_IMPL_WDT;
            6:       impl_mask = `MCRB_IMPL_PD2;
            7:       impl_mask = `MCRB_IMPL_OD;
            8:       impl_mask = `MCRB_IMPL_PH2;
            9:       impl_mask = `MCRB_IMPL_MASK2;
            default: impl_mask = `MCRB_IMPL_MASK1;
        endcase
    endfunction : impl_mask

    function automatic logic [7:0] reset_value(input int idx);
        case (idx)
            0:       reset_value = `MCRB_RST_COUNTER_AND_INT_CONTROL;
            1:       reset_value = `MCRB_RST_DIR5;
            2:       reset_value = `MCRB_RST_DIR6;
            3:       reset_value = `MCRB_RST_DIR7;
            4:       reset_value = `MCRB_RST_DIR8;
            5:       reset_value = `MCRB_RST_WDT;
            6:       reset_value = `MCRB_RST_PD2;
            7:       reset_value = `MCRB_RST_OD;
            8:       reset_value = `MCRB_RST_PH2;
            9:       reset_value = `MCRB_RST_MASK2;
            default: reset_value = `MCRB_RST_MASK1;
        endcase
    endfunction : reset_value

    function automatic logic [4:0] decode_addr(input logic [7:0] addr);
        // {hit, index}; unmapped addresses miss
        case (addr)
            `MCRB_OFS_COUNTER_AND_INT_CONTROL:  decode_addr = {1'b1, `MCRB_IDX_COUNTER_AND_INT_CONTROL};
            `MCRB_OFS_DIR5:  decode_addr = {1'b1, `MCRB_IDX_DIR5};
            `MCRB_OFS_DIR6:  decode_addr = {1'b1, `MCRB_IDX_DIR6};
            `MCRB_OFS_DIR7:  decode_addr = {1'b1, `MCRB_IDX_DIR7};
            `MCRB_OFS_DIR8:  decode_addr = {1'b1, `MCRB_IDX_DIR8};
            `MCRB_OFS_WDT:   decode_addr = {1'b1, `MCRB_IDX_WDT};
            `MCRB_OFS_PD2:   decode_addr = {1'b1, `MCRB_IDX_PD2};
            `MCRB_OFS_OD:    decode_addr = {1'b1, `MCRB_IDX_OD};
            `MCRB_OFS_PH2:   decode_addr = {1'b1, `MCRB_IDX_PH2};
            `MCRB_OFS_MASK2: decode_addr = {1'b1, `MCRB_IDX_MASK2};
            `MCRB_OFS_MASK1: decode_addr = {1'b1, `MCRB_IDX_MASK1};
            default:         decode_addr = 5'h00;
        endcase
    endfunction : decode_addr

    // ---------------- bus decode
    logic [7:0]  regs_r [NREG];
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic [4:0]  dec;
    logic        hit;
    logic [3:0]  idx;
    logic        access;
    logic        wr_fire;
    logic [7:0]  rd_byte;
    logic [NREG-1:0] wr_sel;

    assign dec     = decode_addr(PADDR_IN);
    assign hit     = dec[4];
    assign idx     = dec[3:0];
    // one wait state: pready rises on the second access cycle
    // ready is low again by the next setup, so back-to-back transfers work
    assign access  = PSEL_IN & PENABLE_IN & !pready_r;
    assign wr_fire = PSEL_IN & PENABLE_IN & pready_r & PWRITE_IN & hit;
    // an index past the table is never read: hit gates it
    assign rd_byte = hit ? regs_r[idx] : 8'h00;

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= access;
            prdata_r  <= (access & !PWRITE_IN) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr_r <= access & !hit;
        end
    end

    // ---------------- global interrupt enable
    mcrb_counter_and_int_control_t counter_and_int_control;
    mcrb_wdt_t  wdt;
    logic       gie_set;
    logic       gie_clr;
    logic       gie_nxt;

    assign counter_and_int_control = mcrb_counter_and_int_control_t'(regs_r[`MCRB_IDX_COUNTER_AND_INT_CONTROL]);
    assign wdt  = mcrb_wdt_t'(regs_r[`MCRB_IDX_WDT]);
    assign gie_set = CORE_CMD_IN.enable_irq_instruction
                   | CORE_CMD_IN.return_from_irq_instruction;
    assign gie_clr = CORE_CMD_IN.disable_irq_instruction
                   | CORE_CMD_IN.irq_entry;
    // core commands beat a bus write landing in the same cycle; set beats clear
    assign gie_nxt = gie_set ? 1'b1 :
                     gie_clr ? 1'b0 :
                     wr_sel[`MCRB_IDX_COUNTER_AND_INT_CONTROL] ? PWDATA_IN[`MCRB_COUNTER_AND_INT_CONTROL_GIE_BIT] :
                     counter_and_int_control.global_irq_enable;

    // ---------------- register storage
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            logic [7:0] wdata_masked;
            logic [7:0] reg_nxt;
            // one write strobe per register
            assign wr_sel[gi]   = wr_fire && idx == 4'(gi);
            // reserved bits are masked off before they reach the flops
            assign wdata_masked = PWDATA_IN[7:0] & impl_mask(gi);
            if (gi == `MCRB_IDX_COUNTER_AND_INT_CONTROL) begin : g_counter_and_int_control
                assign reg_nxt = {wr_sel[gi] ? wdata_masked[7] : regs_r[gi][7],
                                  gie_nxt,
                                  wr_sel[gi] ? wdata_masked[5:0] : regs_r[gi][5:0]};
            end else begin : g_plain
                assign reg_nxt = wr_sel[gi] ? wdata_masked : regs_r[gi];
            end
            always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
                if (!RST_N_IN) begin
                    regs_r[gi] <= reset_value(gi);
                end else begin
                    regs_r[gi] <= reg_nxt;
                end
            end
        end
    endgenerate

    // ---------------- accumulator, core-only storage
    logic [7:0] acc_r;

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            acc_r <= 8'h00;
        end else if (ACC_WR_IN) begin
            acc_r <= ACC_DATA_IN;
        end
    end

    // ---------------- pins
    // both pins cross into this clock through two flops first
    logic ipin_level;
    logic ipin_rise;
    logic ipin_fall;
    logic cpin_rise;
    logic cpin_fall;

    mcrb_sync_edge u_irq_pin (
        .clk_in    (CLK_IN),
        .rst_n_in  (RST_N_IN),
        .pin_in    (PORT6_BIT0_PIN_IN),
        .level_out (ipin_level),
        .rise_out  (ipin_rise),
        .fall_out  (ipin_fall)
    );

    mcrb_sync_edge u_cnt_pin (
        .clk_in    (CLK_IN),
        .rst_n_in  (RST_N_IN),
        .pin_in    (COUNTER_PIN_IN),
        .level_out (),
        .rise_out  (cpin_rise),
        .fall_out  (cpin_fall)
    );

    // ---------------- external interrupt edge
    logic ext_sel_edge;
    logic ext_edge;

    assign ext_sel_edge = counter_and_int_control.ext_irq_edge_sel ? ipin_fall : ipin_rise;
    // path masked unless the pin is in its interrupt function
    // the pin's direction bit is not forced here; software must float it
    assign ext_edge     = wdt.irq_pin_function_sel & ext_sel_edge;

    // ---------------- cycle counter tick
    logic cnt_pin_evt;
    logic cnt_src_tick;
    logic cnt_tick;

    assign cnt_pin_evt  = counter_and_int_control.counter_edge_sel ? cpin_fall : cpin_rise;
    assign cnt_src_tick = counter_and_int_control.counter_source_sel ? cnt_pin_evt : INSTR_CYCLE_TICK_IN;

    // prescale counters run on across ratio changes, so the first period after one may be short
    mcrb_prescaler #(.W(`MCRB_PRESCALE_W)) u_cnt_pre (
        .clk_in    (CLK_IN),
        .rst_n_in  (RST_N_IN),
        .enable_in (counter_and_int_control.counter_prescale_enable),
        .sel_in    (counter_and_int_control.counter_prescale_sel),
        .tick_in   (cnt_src_tick),
        .tick_out  (cnt_tick)
    );

    // ---------------- watchdog tick
    logic wdt_tick;

    mcrb_prescaler #(.W(`MCRB_PRESCALE_W)) u_wdt_pre (
        .clk_in    (CLK_IN),
        .rst_n_in  (RST_N_IN),
        .enable_in (wdt.watchdog_prescale_enable),
        .sel_in    (wdt.watchdog_prescale_sel),
        .tick_in   (WDT_CLK_TICK_IN),
        .tick_out  (wdt_tick)
    );

    // ---------------- interrupt request
    // registered, so the request trails the flags by one edge
    logic [7:0] pend1;
    logic [7:0] pend2;
    logic       irq_nxt;

    assign pend1   = IRQ_FLAGS1_IN & regs_r[`MCRB_IDX_MASK1];
    assign pend2   = IRQ_FLAGS2_IN & regs_r[`MCRB_IDX_MASK2];
    assign irq_nxt = counter_and_int_control.global_irq_enable & (|pend1 | |pend2);

    // ---------------- registered outputs
    // every pulse leaves through a flop, so the outputs never glitch
    logic irq_r;
    logic ext_r;
    logic cnt_r;
    logic wdt_r;
    logic p60_r;

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            irq_r <= 1'b0;
            ext_r <= 1'b0;
            cnt_r <= 1'b0;
            wdt_r <= 1'b0;
            p60_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
            ext_r <= ext_edge;
            cnt_r <= cnt_tick;
            wdt_r <= wdt_tick & wdt.watchdog_enable;
            p60_r <= ipin_level;
        end
    end

    assign PREADY_OUT          = pready_r;
    assign PRDATA_OUT          = prdata_r;
    assign PSLVERR_OUT         = pslverr_r;
    assign ACC_OUT             = acc_r;
    assign IRQ_REQ_OUT         = irq_r;
    assign EXT_IRQ_EDGE_OUT    = ext_r;
    assign COUNTER_INC_OUT     = cnt_r;
    assign WDT_TICK_OUT        = wdt_r;
    assign WDT_ENABLE_OUT      = wdt.watchdog_enable;
    assign PORT6_BIT0_READ_OUT = p60_r;
    // direction 0 drives the pad, 1 floats it
    assign PORT5_DIR_OUT       = regs_r[`MCRB_IDX_DIR5];
    assign PORT6_DIR_OUT       = regs_r[`MCRB_IDX_DIR6];
    assign PORT7_DIR_OUT       = regs_r[`MCRB_IDX_DIR7];
    assign PORT8_DIR_OUT       = regs_r[`MCRB_IDX_DIR8];
    assign PULL_DOWN2_N_OUT    = regs_r[`MCRB_IDX_PD2];
    assign OPEN_DRAIN_OUT      = regs_r[`MCRB_IDX_OD];
    assign PULL_HIGH2_N_OUT    = regs_r[`MCRB_IDX_PH2];

endmodule : mcrb_top
`default_nettype wire

/* verilog/mcrb_defs.svh */
`ifndef MCRB_DEFS_SVH
`define MCRB_DEFS_SVH

// byte offsets on the register bus
`define MCRB_OFS_COUNTER_AND_INT_CONTROL      8'h00
`define MCRB_OFS_DIR5      8'h04
`define MCRB_OFS_DIR6      8'h08
`define MCRB_OFS_DIR7      8'h0C
`define MCRB_OFS_DIR8      8'h10
`define MCRB_OFS_WDT       8'h14
`define MCRB_OFS_PD2       8'h18
`define MCRB_OFS_OD        8'h1C
`define MCRB_OFS_PH2       8'h20
`define MCRB_OFS_MASK2     8'h24
`define MCRB_OFS_MASK1     8'h28

// register indices
`define MCRB_IDX_COUNTER_AND_INT_CONTROL      4'd0
`define MCRB_IDX_DIR5      4'd1
`define MCRB_IDX_DIR6      4'd2
`define MCRB_IDX_DIR7      4'd3
`define MCRB_IDX_DIR8      4'd4
`define MCRB_IDX_WDT       4'd5
`define MCRB_IDX_PD2       4'd6
`define MCRB_IDX_OD        4'd7
`define MCRB_IDX_PH2       4'd8
`define MCRB_IDX_MASK2     4'd9
`define MCRB_IDX_MASK1     4'd10
`define MCRB_NUM_REGS      11

// implemented-bit masks
`define MCRB_IMPL_COUNTER_AND_INT_CONTROL     8'hFF
`define MCRB_IMPL_DIR5     8'hFF
`define MCRB_IMPL_DIR6     8'hFF
`define MCRB_IMPL_DIR7     8'hFC
`define MCRB_IMPL_DIR8     8'h0F
`define MCRB_IMPL_WDT      8'hCF
`define MCRB_IMPL_PD2      8'hFF
`define MCRB_IMPL_OD       8'hFF
`define MCRB_IMPL_PH2      8'hFF
`define MCRB_IMPL_MASK2    8'hBF
`define MCRB_IMPL_MASK1    8'h3F

// reset values
`define MCRB_RST_COUNTER_AND_INT_CONTROL      8'h00
`define MCRB_RST_DIR5      8'hFF
`define MCRB_RST_DIR6      8'hFF
`define MCRB_RST_DIR7      8'hFC
`define MCRB_RST_DIR8      8'h0F
`define MCRB_RST_WDT       8'h00
`define MCRB_RST_PD2       8'hFF
`define MCRB_RST_OD        8'h00
`define MCRB_RST_PH2       8'hFF
`define MCRB_RST_MASK2     8'h00
`define MCRB_RST_MASK1     8'h00

// field positions and widths
`define MCRB_COUNTER_AND_INT_CONTROL_GIE_BIT  6
`define MCRB_ADDR_W        8
`define MCRB_PRESCALE_W    8

`endif

/* verilog/mcrb_pkg.sv */
`default_nettype none
package mcrb_pkg;

    typedef struct packed {
        logic       ext_irq_edge_sel;
        logic       global_irq_enable;
        logic       counter_source_sel;
        logic       counter_edge_sel;
        logic       counter_prescale_enable;
        logic [2:0] counter_prescale_sel;
    } mcrb_counter_and_int_control_t;

    typedef struct packed {
        logic       watchdog_enable;
        logic       irq_pin_function_sel;
        logic [1:0] unused;
        logic       watchdog_prescale_enable;
        logic [2:0] watchdog_prescale_sel;
    } mcrb_wdt_t;

    typedef struct packed {
        logic disable_irq_instruction;
        logic enable_irq_instruction;
        logic return_from_irq_instruction;
        logic irq_entry;
    } mcrb_core_cmd_t;

endpackage : mcrb_pkg
`default_nettype wire

/* verilog/mcrb_sync_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module mcrb_sync_edge (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // pin and results
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // first stage feeds only the second
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level_out = sync_r;
    assign rise_out  = sync_r & ~prev_r;
    assign fall_out  = ~sync_r & prev_r;
endmodule : mcrb_sync_edge
`default_nettype wire

/* verilog/mcrb_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module mcrb_prescaler #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // control
    input  wire logic       enable_in,
    input  wire logic [2:0] sel_in,
    // ticks
    input  wire logic       tick_in,
    output logic            tick_out
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] wrap_mask;

    // ratio is 2**(sel+1): pulse when the low sel+1 bits are all ones
    assign wrap_mask = W'((16'h0002 << sel_in) - 16'h0001);
    assign tick_out  = tick_in & (!enable_in | ((cnt_r & wrap_mask) == wrap_mask));

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= '0;
        end else if (tick_in) begin
            cnt_r <= cnt_r + W'(1);
        end
    end
endmodule : mcrb_prescaler
`default_nettype wire

/* tb/mcrb_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mcrb_checker
    import mcrb_pkg::*;
(
    // clock and reset
    input wire logic           CLK_IN,
    input wire logic           RST_N_IN,
    // apb
    input wire logic           PSEL_IN,
    input wire logic           PENABLE_IN,
    input wire logic           PREADY_OUT,
    input wire logic [31:0]    PRDATA_OUT,
    input wire logic           PSLVERR_OUT,
    // core and interrupts
    input wire mcrb_core_cmd_t CORE_CMD_IN,
    input wire logic [7:0]     IRQ_FLAGS1_IN,
    input wire logic [7:0]     IRQ_FLAGS2_IN,
    input wire logic           IRQ_REQ_OUT,
    // watchdog and pads
    input wire logic           WDT_TICK_OUT,
    input wire logic           WDT_ENABLE_OUT,
    input wire logic [7:0]     PORT7_DIR_OUT,
    input wire logic [7:0]     PORT8_DIR_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    wire any_flag;
    wire gie_set;
    wire gie_clr;
    assign any_flag = (|IRQ_FLAGS1_IN) | (|IRQ_FLAGS2_IN);
    assign gie_set  = CORE_CMD_IN.enable_irq_instruction | CORE_CMD_IN.return_from_irq_instruction;
    assign gie_clr  = CORE_CMD_IN.disable_irq_instruction | CORE_CMD_IN.irq_entry;

    property p_dir7_low; PORT7_DIR_OUT[1:0] == 2'h0; endproperty
    a_dir7_low: assert property (p_dir7_low) else $error("port seven low bits set");
    property p_dir8_high; PORT8_DIR_OUT[7:4] == 4'h0; endproperty
    a_dir8_high: assert property (p_dir8_high) else $error("port eight high bits set");
    // the tick is registered, so allow the pipe to drain before demanding silence
    property p_wdt_gate; !WDT_ENABLE_OUT [*3] |=> !WDT_TICK_OUT; endproperty
    a_wdt_gate: assert property (p_wdt_gate) else $error("watchdog tick while disabled");
    property p_gie_clr; gie_clr && !gie_set ##1 !gie_set |=> !IRQ_REQ_OUT; endproperty
    a_gie_clr: assert property (p_gie_clr) else $error("request after global disable");
    property p_irq_flag; IRQ_REQ_OUT |-> $past(any_flag); endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("request without source flag");
    property p_answer; PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT; endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");
    property p_ready_pulse; PREADY_OUT |-> (PSEL_IN && PENABLE_IN) ##1 !PREADY_OUT; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready not a single pulse");
    property p_err_ready; PSLVERR_OUT |-> PREADY_OUT; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_rdata_idle;
        (PREADY_OUT || PRDATA_OUT == 32'h0000_0000) && PRDATA_OUT[31:8] == 24'h00_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data upper bits set");
endmodule : mcrb_checker

bind mcrb_top mcrb_checker u_chk (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PREADY_OUT(PREADY_OUT), .PRDATA_OUT(PRDATA_OUT), .PSLVERR_OUT(PSLVERR_OUT), .CORE_CMD_IN(CORE_CMD_IN),
    .IRQ_FLAGS1_IN(IRQ_FLAGS1_IN), .IRQ_FLAGS2_IN(IRQ_FLAGS2_IN), .IRQ_REQ_OUT(IRQ_REQ_OUT),
    .WDT_TICK_OUT(WDT_TICK_OUT), .WDT_ENABLE_OUT(WDT_ENABLE_OUT),
    .PORT7_DIR_OUT(PORT7_DIR_OUT), .PORT8_DIR_OUT(PORT8_DIR_OUT)
);
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mcrb_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
    import mcrb_pkg::*;
;
    logic           clk, rst_n, psel, penable, pwrite, pready, pslverr, acc_wr, irq_req, ext_edge;
    logic           cnt_pin, cnt_inc, instr_tick, wdt_in, wdt_tick, wdt_en, p6_pin, p6_rd;
    logic [7:0]     paddr, acc_data, acc, flags1, flags2, dir5, dir6, dir7, dir8, pd2_n, od, ph2_n;
    logic [31:0]    pwdata, prdata;
    mcrb_core_cmd_t cmd;
    int             error_cnt, comparisons, inc_cnt, wdt_cnt, ext_cnt;

    mcrb_top dut (
        .CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr),
        .CORE_CMD_IN(cmd), .ACC_WR_IN(acc_wr), .ACC_DATA_IN(acc_data), .ACC_OUT(acc),
        .IRQ_FLAGS1_IN(flags1), .IRQ_FLAGS2_IN(flags2), .IRQ_REQ_OUT(irq_req), .EXT_IRQ_EDGE_OUT(ext_edge),
        .INSTR_CYCLE_TICK_IN(instr_tick), .COUNTER_PIN_IN(cnt_pin), .COUNTER_INC_OUT(cnt_inc),
        .WDT_CLK_TICK_IN(wdt_in), .WDT_TICK_OUT(wdt_tick), .WDT_ENABLE_OUT(wdt_en),
        .PORT6_BIT0_PIN_IN(p6_pin), .PORT6_BIT0_READ_OUT(p6_rd), .PORT5_DIR_OUT(dir5), .PORT6_DIR_OUT(dir6),
        .PORT7_DIR_OUT(dir7), .PORT8_DIR_OUT(dir8), .PULL_DOWN2_N_OUT(pd2_n), .OPEN_DRAIN_OUT(od),
        .PULL_HIGH2_N_OUT(ph2_n)
    );

    always #2 clk = ~clk;

    // pulses are counted mid-cycle, where they have settled
    always @(negedge clk) begin
        if (cnt_inc === 1'b1) inc_cnt++;
        if (wdt_tick === 1'b1) wdt_cnt++;
        if (ext_edge === 1'b1) ext_cnt++;
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int   n;
        logic rdy;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // ready, data and error are taken at the edge itself, before the slave's flops move
        do begin
            @(posedge clk);
            rdy = pready;
            rd  = prdata;
            err = pslverr;
            n++;
        end while (rdy !== 1'b1 && n < 50);
        `CHK(rdy, 1'b1)
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h00_0000, d}, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic e);
        apb(1'b0, a, 32'h0000_0000, d, e);
    endtask : rd

    task automatic core(input logic [3:0] c, input logic exp);
        @(posedge clk);
        cmd <= mcrb_core_cmd_t'(c);
        @(posedge clk);
        cmd <= '0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK(irq_req, exp)
    endtask : core

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            instr_tick <= 1'b1;
            wdt_in     <= 1'b1;
            @(posedge clk);
            instr_tick <= 1'b0;
            wdt_in     <= 1'b0;
        end
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask : ticks

    // instruction ticks run alongside so a wrong counter source shows up
    task automatic pin_wave(input logic cnt, input int n, output int r, output int f);
        r = 0;
        f = 0;
        repeat (n) begin
            @(posedge clk);
            if (cnt) cnt_pin <= ~cnt_pin;
            else p6_pin <= ~p6_pin;
            if ((cnt ? cnt_pin : p6_pin) === 1'b0) r++;
            else f++;
            instr_tick <= 1'b1;
            @(posedge clk);
            instr_tick <= 1'b0;
            repeat (6) @(posedge clk);
        end
        @(negedge clk);
    endtask : pin_wave

    task automatic t_regs();
        logic [7:0]  rst_v [11];
        logic [7:0]  impl [11];
        logic [31:0] v;
        logic        e;
        rst_v = '{8'h00, 8'hFF, 8'hFF, 8'hFC, 8'h0F, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};
        impl  = '{8'hFF, 8'hFF, 8'hFF, 8'hFC, 8'h0F, 8'hCF, 8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'h3F};
        for (int i = 0; i < 11; i++) begin
            rd(8'(i * 4), v, e);
            `CHK(v, {24'h00_0000, rst_v[i]})
            wr(8'(i * 4), 8'hFF);
            rd(8'(i * 4), v, e);
            `CHK({e, v}, {25'h000_0000, impl[i]})
        end
        `CHK({dir5, dir6, dir7, dir8}, 32'hFFFF_FC0F)
        `CHK({pd2_n, od, ph2_n, wdt_en}, 25'h1FF_FFFF)
        for (int i = 0; i < 11; i++) begin
            wr(8'(i * 4), 8'h00);
            rd(8'(i * 4), v, e);
            `CHK(v, 32'h0000_0000)
        end
        `CHK({dir5, dir6, dir7, dir8, pd2_n, od, ph2_n, wdt_en}, 57'h0)
        rd(8'h2C, v, e);
        `CHK({e, v}, 33'h1_0000_0000)
        wr(8'h2C, 8'hFF);
        rd(`MCRB_OFS_DIR5, v, e);
        `CHK(v, 32'h0000_0000)
        @(posedge clk);
        acc_wr   <= 1'b1;
        acc_data <= 8'hC3;
        @(posedge clk);
        acc_wr <= 1'b0;
        @(negedge clk);
        `CHK(acc, 8'hC3)
    endtask : t_regs

    task automatic t_irq();
        logic [31:0] v;
        logic        e;
        wr(`MCRB_OFS_MASK1, 8'hFF);
        wr(`MCRB_OFS_MASK2, 8'hFF);
        flags1 <= 8'h04;
        core(4'b0000, 1'b0);
        core(4'b0100, 1'b1);
        rd(`MCRB_OFS_COUNTER_AND_INT_CONTROL, v, e);
        `CHK(v, 32'h0000_0040)
        core(4'b1000, 1'b0);
        core(4'b0010, 1'b1);
        core(4'b0001, 1'b0);
        core(4'b0100, 1'b1);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            {flags2, flags1} <= 16'h0001 << i;
            repeat (3) @(posedge clk);
            @(negedge clk);
            `CHK(irq_req, (i != 6 && i != 7 && i != 14))
        end
        wr(`MCRB_OFS_MASK2, 8'h7F);
        core(4'b0000, 1'b0);
        @(posedge clk);
        flags2 <= 8'h00;
        core(4'b1000, 1'b0);
    endtask : t_irq

    task automatic t_rates();
        int b1;
        int b2;
        wr(`MCRB_OFS_WDT, 8'h80);
        b1 = inc_cnt;
        b2 = wdt_cnt;
        ticks(8);
        `CHK(inc_cnt - b1, 8)
        `CHK(wdt_cnt - b2, 8)
        wr(`MCRB_OFS_WDT, 8'h08);
        b2 = wdt_cnt;
        ticks(8);
        `CHK(wdt_cnt - b2, 0)
        // two full periods per ratio, so the free-running phase cannot matter
        for (int s = 0; s < 8; s++) begin
            wr(`MCRB_OFS_COUNTER_AND_INT_CONTROL, 8'(8 + s));
            wr(`MCRB_OFS_WDT, 8'(8'h88 + s));
            b1 = inc_cnt;
            b2 = wdt_cnt;
            ticks(4 << s);
            `CHK(inc_cnt - b1, 2)
            `CHK(wdt_cnt - b2, 2)
        end
    endtask : t_rates

    task automatic t_pins();
        int b;
        int r;
        int f;
        wr(`MCRB_OFS_COUNTER_AND_INT_CONTROL, 8'h20);
        b = inc_cnt;
        pin_wave(1'b1, 5, r, f);
        `CHK(inc_cnt - b, r)
        wr(`MCRB_OFS_COUNTER_AND_INT_CONTROL, 8'h30);
        b = inc_cnt;
        pin_wave(1'b1, 5, r, f);
        `CHK(inc_cnt - b, f)
        wr(`MCRB_OFS_COUNTER_AND_INT_CONTROL, 8'h00);
        wr(`MCRB_OFS_WDT, 8'h00);
        b = ext_cnt;
        pin_wave(1'b0, 4, r, f);
        `CHK(ext_cnt - b, 0)
        wr(`MCRB_OFS_DIR6, 8'h01);
        wr(`MCRB_OFS_WDT, 8'h40);
        b = ext_cnt;
        pin_wave(1'b0, 5, r, f);
        `CHK(ext_cnt - b, r)
        `CHK(p6_rd, p6_pin)
        wr(`MCRB_OFS_COUNTER_AND_INT_CONTROL, 8'h80);
        b = ext_cnt;
        pin_wave(1'b0, 5, r, f);
        `CHK(ext_cnt - b, f)
    endtask : t_pins

    initial begin
        clk   = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, acc_wr, instr_tick, cnt_pin, wdt_in, p6_pin} = '0;
        {paddr, pwdata, acc_data, flags1, flags2} = '0;
        cmd = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_irq();
        t_rates();
        t_pins();
        report_and_stop();
    end

    // the whole run needs a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
